// *** design/sfda_pkg.sv ***
// constants, register map and state type for the flag and address datapath slice
// assumes one clock domain shared with the instruction sequencer and the bus
package sfda_pkg;
  // flag bit positions inside the five implemented flag bits
  localparam int unsigned FL_C = 0;
  localparam int unsigned FL_DC = 1;
  localparam int unsigned FL_Z = 2;
  localparam int unsigned FL_OV = 3;
  localparam int unsigned FL_N = 4;
  localparam logic [4:0] FLAGS_RST = 5'h00;

  // operation codes on the instruction port
  localparam logic [3:0] OP_ADD_WORKING_FILE_INSTR = 4'h0;
  localparam logic [3:0] OP_ADD_LITERAL_INSTR = 4'h1;
  localparam logic [3:0] OP_SUBTRACT_FROM_LITERAL_INSTR = 4'h2;
  localparam logic [3:0] OP_SUBTRACT_WORKING_INSTR = 4'h3;
  localparam logic [3:0] OP_ANDWF = 4'h4;
  localparam logic [3:0] OP_IORWF = 4'h5;
  localparam logic [3:0] OP_XORWF = 4'h6;
  localparam logic [3:0] OP_CLEAR_FILE_INSTR = 4'h7;
  localparam logic [3:0] OP_RRCF = 4'h8;
  localparam logic [3:0] OP_RLCF = 4'h9;
  localparam logic [3:0] OP_WORKING_TO_FILE_MOVE_INSTR = 4'ha;
  localparam logic [3:0] OP_BCF = 4'hb;
  localparam logic [3:0] OP_BSF = 4'hc;
  localparam logic [3:0] OP_NIBBLE_SWAP_INSTR = 4'hd;
  localparam logic [3:0] OP_FILE_TO_FILE_MOVE_INSTR = 4'he;
  localparam logic [3:0] OP_JUMP = 4'hf;

  // data space map
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [11:0] ADDR_VIRT = 12'hfc0;
  localparam logic [11:0] ADDR_FLAGS = 12'hfd8;
  localparam logic [11:0] ADDR_BSR = 12'hfd9;
  // slot within each pointer's 8-byte block
  localparam logic [2:0] VK_INDIRECT_FILE_OPERAND = 3'h0;
  localparam logic [2:0] VK_POST_INCREMENT_OPERAND = 3'h1;
  localparam logic [2:0] VK_POSTDEC = 3'h2;
  localparam logic [2:0] VK_PREINC = 3'h3;
  localparam logic [2:0] VK_PLUSW = 3'h4;
  localparam logic [2:0] VK_LO = 3'h5;
  localparam logic [2:0] VK_HI = 3'h6;
  localparam logic [1:0] NUM_PTR = 2'h3;

  // bus register byte offsets
  localparam logic [5:0] REG_FLAGS = 6'h00;
  localparam logic [5:0] REG_W = 6'h04;
  localparam logic [5:0] REG_BSR = 6'h08;
  localparam logic [5:0] REG_CTRL = 6'h0c;
  localparam logic [5:0] REG_PTR0 = 6'h10;
  localparam logic [5:0] REG_PTR1 = 6'h14;
  localparam logic [5:0] REG_PTR2 = 6'h18;
  localparam logic [5:0] REG_LAST_EA = 6'h1c;
  localparam logic [5:0] REG_JUMP = 6'h20;
  localparam int unsigned CTRL_EXT = 0;

  typedef struct packed {
    logic [4:0] flags;
    logic [7:0] w;
    logic [3:0] bank_select_register;
    logic ext;
    logic [2:0][11:0] ptr;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic [19:0] jump;
    logic jump_v;
    logic wreq;
    logic [31:0] rdata;
  } sfda_state_s;
endpackage

// *** design/sfda_core.sv ***
// flag generation, effective address forming and writeback for the 8-bit core
// assumes the sequencer presents one instruction per instr_valid cycle with its
// source byte on file_rdata, all on sys_clk; software uses an avalon-mm master
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - flag-affecting instruction aimed at flags discards result, updates flags instead.
// - clear-file on flags sets only zero flag, others unchanged.
// - subtract adds two's complement; carry and digit carry mean not-borrow.
// - flag register upper three bits read zero; five flags read/write.
// - negative flag follows result bit seven.
// - overflow flag set when signed result overflows into the sign bit.
// - zero flag set when the result equals zero.
// - add/subtract digit carry records carry out of low nibble.
// - add/subtract carry records carry out of bit seven.
// - rotates load digit carry from bit four or three, carry from end bit.
// - inherent, literal, direct, indirect; indexed offset only with extended enable.
// - call and jump carry a twenty-bit program address.
// - byte and bit instructions carry an eight-bit file address.
// - access bit one joins bank select with file address into twelve bits.
// - access bit zero maps file address into access bank, ignoring bank.
// - full twelve-bit address in encoding is used directly, ignoring bank.
// - destination bit one writes file register, zero writes working register.
// - indirect access uses pointer register value as data address.
// - indirect operands post-increment, post-decrement or offset the pointer.
// - pointer is a byte pair giving a twelve-bit address.
// - indirect address ignores bank select and access bit.
// - pointer steps carry across the pair and leave flags alone.
module sfda_core
  import sfda_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic instr_valid,
  input wire logic [3:0] instr_op,
  input wire logic [7:0] instr_file_addr,
  input wire logic instr_a,
  input wire logic instr_d,
  input wire logic [2:0] instr_bit,
  input wire logic [7:0] instr_literal,
  input wire logic [11:0] instr_dst_addr,
  input wire logic [19:0] instr_prog_addr,
  input wire logic [7:0] file_rdata,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic [7:0] flags_out,
  output logic [7:0] w_out,
  output logic [19:0] jump_target,
  output logic jump_valid
);
  sfda_state_s st;
  sfda_state_s nx;

  logic [31:0] bus_rd;
  logic [11:0] direct_ea;
  logic [11:0] ea;
  logic [11:0] ta;
  logic [11:0] pp;
  logic [1:0] pn;
  logic [2:0] vk;
  logic in_blk;
  logic virt;
  logic [7:0] fop;
  logic [7:0] a_op;
  logic [7:0] b_op;
  logic is_sub;
  logic [8:0] sum9;
  logic [4:0] nib;
  logic [7:0] res;
  logic [4:0] fl;
  logic upd;
  logic to_w;

  always_comb begin
    unique case (avs_address)
      REG_FLAGS: bus_rd = {27'h0, st.flags};
      REG_W: bus_rd = {24'h0, st.w};
      REG_BSR: bus_rd = {28'h0, st.bank_select_register};
      REG_CTRL: bus_rd = {31'h0, st.ext};
      REG_PTR0: bus_rd = {20'h0, st.ptr[0]};
      REG_PTR1: bus_rd = {20'h0, st.ptr[1]};
      REG_PTR2: bus_rd = {20'h0, st.ptr[2]};
      REG_LAST_EA: bus_rd = {20'h0, st.mem_addr};
      REG_JUMP: bus_rd = {12'h0, st.jump};
      default: bus_rd = 32'h0;
    endcase
  end

  always_comb begin
    // direct address from the 8-bit file field
    if (instr_a) begin
      direct_ea = {st.bank_select_register, instr_file_addr};
    end else if (instr_file_addr >= ACC_SPLIT) begin
      direct_ea = {ACC_HI_BANK, instr_file_addr};
    end else begin
      direct_ea = {4'h0, instr_file_addr};
    end
    if (instr_op == OP_FILE_TO_FILE_MOVE_INSTR) begin
      ea = instr_dst_addr;
    end else if (st.ext && !instr_a && instr_file_addr < ACC_SPLIT) begin
      ea = st.ptr[2] + {4'h0, instr_file_addr};
    end else begin
      ea = direct_ea;
    end
    in_blk = (ea[11:5] == ADDR_VIRT[11:5]) && (ea[4:3] != NUM_PTR);
    pn = ea[4:3];
    vk = ea[2:0];
    virt = in_blk && (vk <= VK_PLUSW);
    pp = in_blk ? st.ptr[pn] : 12'h000;
    // indirect target ignores bank and access bit
    ta = ea;
    if (virt) begin
      unique case (vk)
        VK_PREINC: ta = pp + 12'h001;
        VK_PLUSW: ta = pp + {{4{st.w[7]}}, st.w};
        default: ta = pp;
      endcase
    end
    // internal registers are read here, the rest arrives on file_rdata
    if (ta == ADDR_FLAGS) begin
      fop = {3'h0, st.flags};
    end else if (ta == ADDR_BSR) begin
      fop = {4'h0, st.bank_select_register};
    end else if (in_blk && !virt && ta == ea && vk == VK_LO) begin
      fop = pp[7:0];
    end else if (in_blk && !virt && ta == ea && vk == VK_HI) begin
      fop = {4'h0, pp[11:8]};
    end else begin
      fop = file_rdata;
    end
  end

  always_comb begin
    is_sub = (instr_op == OP_SUBTRACT_FROM_LITERAL_INSTR) || (instr_op == OP_SUBTRACT_WORKING_INSTR);
    a_op = (instr_op == OP_ADD_LITERAL_INSTR || instr_op == OP_SUBTRACT_FROM_LITERAL_INSTR) ? instr_literal : fop;
    b_op = is_sub ? ~st.w : st.w;
    sum9 = {1'b0, a_op} + {1'b0, b_op} + {8'h00, is_sub};
    nib = {1'b0, a_op[3:0]} + {1'b0, b_op[3:0]} + {4'h0, is_sub};
    fl = st.flags;
    upd = 1'b1;
    to_w = 1'b0;
    res = 8'h00;
    unique case (instr_op)
      OP_ADD_WORKING_FILE_INSTR, OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR, OP_SUBTRACT_WORKING_INSTR: begin
        res = sum9[7:0];
        fl[FL_C] = sum9[8];
        fl[FL_DC] = nib[4];
        fl[FL_OV] = (a_op[7] == b_op[7]) && (res[7] != a_op[7]);
      end
      OP_ANDWF: res = fop & st.w;
      OP_IORWF: res = fop | st.w;
      OP_XORWF: res = fop ^ st.w;
      OP_CLEAR_FILE_INSTR: res = 8'h00;
      OP_RRCF: begin
        res = {st.flags[FL_C], fop[7:1]};
        fl[FL_C] = fop[0];
        fl[FL_DC] = fop[4];
      end
      OP_RLCF: begin
        res = {fop[6:0], st.flags[FL_C]};
        fl[FL_C] = fop[7];
        fl[FL_DC] = fop[3];
      end
      OP_WORKING_TO_FILE_MOVE_INSTR: begin
        res = st.w;
        upd = 1'b0;
      end
      OP_BCF: begin
        res = fop & ~(8'h01 << instr_bit);
        upd = 1'b0;
      end
      OP_BSF: begin
        res = fop | (8'h01 << instr_bit);
        upd = 1'b0;
      end
      OP_NIBBLE_SWAP_INSTR: begin
        res = {fop[3:0], fop[7:4]};
        upd = 1'b0;
      end
      OP_FILE_TO_FILE_MOVE_INSTR: begin
        res = file_rdata;
        upd = 1'b0;
      end
      OP_JUMP: upd = 1'b0;
    endcase
    if (instr_op == OP_CLEAR_FILE_INSTR) begin
      fl[FL_Z] = 1'b1;
    end else begin
      fl[FL_Z] = (res == 8'h00);
    end
    if (instr_op != OP_CLEAR_FILE_INSTR && instr_op != OP_ANDWF && instr_op != OP_IORWF
        && instr_op != OP_XORWF && !upd) begin
      fl = st.flags;
    end
    fl[FL_N] = (instr_op == OP_CLEAR_FILE_INSTR || !upd) ? st.flags[FL_N] : res[7];
    unique case (instr_op)
      OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR: to_w = 1'b1;
      OP_ADD_WORKING_FILE_INSTR, OP_SUBTRACT_WORKING_INSTR, OP_ANDWF, OP_IORWF, OP_XORWF, OP_RRCF, OP_RLCF, OP_NIBBLE_SWAP_INSTR:
        to_w = !instr_d;
      default: to_w = 1'b0;
    endcase
  end

  always_comb begin
    nx = st;
    nx.mem_we = 1'b0;
    nx.jump_v = 1'b0;
    // two-cycle bus answer: waitrequest drops one cycle after the request
    nx.wreq = 1'b1;
    if ((avs_read || avs_write) && st.wreq) begin
      nx.wreq = 1'b0;
      nx.rdata = bus_rd;
    end
    if (avs_write && !st.wreq) begin
      unique case (avs_address)
        REG_FLAGS: nx.flags = avs_writedata[4:0];
        REG_W: nx.w = avs_writedata[7:0];
        REG_BSR: nx.bank_select_register = avs_writedata[3:0];
        REG_CTRL: nx.ext = avs_writedata[CTRL_EXT];
        REG_PTR0: nx.ptr[0] = avs_writedata[11:0];
        REG_PTR1: nx.ptr[1] = avs_writedata[11:0];
        REG_PTR2: nx.ptr[2] = avs_writedata[11:0];
        default: nx.rdata = st.rdata;
      endcase
    end
    // the instruction stream wins over a bus write in the same cycle
    if (instr_valid && instr_op == OP_JUMP) begin
      nx.jump = instr_prog_addr;
      nx.jump_v = 1'b1;
    end else if (instr_valid) begin
      nx.mem_addr = ta;
      if (virt && vk == VK_POST_INCREMENT_OPERAND) begin
        nx.ptr[pn] = pp + 12'h001;
      end else if (virt && vk == VK_POSTDEC) begin
        nx.ptr[pn] = pp - 12'h001;
      end else if (virt && vk == VK_PREINC) begin
        nx.ptr[pn] = pp + 12'h001;
      end
      if (upd) begin
        nx.flags = fl;
      end
      if (to_w) begin
        nx.w = res;
      end else if (ta == ADDR_FLAGS) begin
        // a flag-affecting result aimed at the flags is dropped
        if (!upd) begin
          nx.flags = res[4:0];
        end
      end else if (ta == ADDR_BSR) begin
        nx.bank_select_register = res[3:0];
      end else if (in_blk && !virt && vk == VK_LO) begin
        nx.ptr[pn][7:0] = res;
      end else if (in_blk && !virt && vk == VK_HI) begin
        nx.ptr[pn][11:8] = res[3:0];
      end else begin
        nx.mem_we = 1'b1;
        nx.mem_wdata = res;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.flags <= FLAGS_RST;
      st.wreq <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.wreq;
  assign mem_addr = st.mem_addr;
  assign mem_wdata = st.mem_wdata;
  assign mem_we = st.mem_we;
  assign flags_out = {3'h0, st.flags};
  assign w_out = st.w;
  assign jump_target = st.jump;
  assign jump_valid = st.jump_v;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic quiet_bus;
  assign quiet_bus = !avs_write;

  a_neg_flag: assert property (
    instr_valid && instr_op == OP_ADD_LITERAL_INSTR |=> flags_out[FL_N] == w_out[7])
    else $error("negative flag does not follow result msb");
  a_zero_flag: assert property (
    instr_valid && instr_op == OP_SUBTRACT_FROM_LITERAL_INSTR |=> flags_out[FL_Z] == (w_out == 8'h00))
    else $error("zero flag does not match result");
  a_add_carry: assert property (
    instr_valid && instr_op == OP_ADD_LITERAL_INSTR
    |=> flags_out[FL_C] == (({1'b0, $past(instr_literal)} + {1'b0, $past(st.w)}) > 9'h0ff))
    else $error("add carry wrong");
  a_sub_borrow: assert property (
    instr_valid && instr_op == OP_SUBTRACT_FROM_LITERAL_INSTR
    |=> flags_out[FL_C] == ($past(instr_literal) >= $past(st.w)))
    else $error("subtract borrow polarity wrong");
  a_clear_file_instr_flags: assert property (
    instr_valid && instr_op == OP_CLEAR_FILE_INSTR && !instr_a && instr_file_addr == ADDR_FLAGS[7:0]
    |=> flags_out == {3'h0, $past(st.flags[4:3]), 1'b1, $past(st.flags[1:0])} && !mem_we)
    else $error("clear of flags register wrong");
  a_flag_dest: assert property (
    instr_valid && instr_op == OP_ADD_WORKING_FILE_INSTR && instr_d && !instr_a
    && instr_file_addr == ADDR_FLAGS[7:0] |=> !mem_we && w_out == $past(st.w))
    else $error("result written despite flag destination");
  a_bank_addr: assert property (
    instr_valid && instr_op == OP_ADD_WORKING_FILE_INSTR && instr_a && st.bank_select_register != ACC_HI_BANK
    |=> mem_addr == {$past(st.bank_select_register), $past(instr_file_addr)})
    else $error("banked address wrong");
  a_access_addr: assert property (
    instr_valid && instr_op == OP_ADD_WORKING_FILE_INSTR && !instr_a && !st.ext && instr_file_addr < ACC_SPLIT
    |=> mem_addr == {4'h0, $past(instr_file_addr)})
    else $error("access bank address wrong");
  a_post_increment_operand_ptr: assert property (
    instr_valid && instr_op != OP_FILE_TO_FILE_MOVE_INSTR && instr_op != OP_JUMP && !instr_a
    && instr_file_addr == ADDR_VIRT[7:0] + {5'h00, VK_POST_INCREMENT_OPERAND}
    |=> mem_addr == $past(st.ptr[0]) && st.ptr[0] == $past(st.ptr[0]) + 12'h001)
    else $error("post increment pointer wrong");
  a_dest_w: assert property (
    instr_valid && instr_op == OP_ANDWF && !instr_d
    |=> !mem_we && w_out == ($past(fop) & $past(st.w)))
    else $error("working destination wrote memory");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");

  c_add_literal_instr: cover property (instr_valid && instr_op == OP_ADD_LITERAL_INSTR ##1 flags_out[FL_OV]);
  c_clear_file_instr_flags: cover property (instr_valid && instr_op == OP_CLEAR_FILE_INSTR && !instr_a
    && instr_file_addr == ADDR_FLAGS[7:0]);
  c_post_increment_operand: cover property (instr_valid && !instr_a
    && instr_file_addr == ADDR_VIRT[7:0] + {5'h00, VK_POST_INCREMENT_OPERAND});
  c_bus_read: cover property (avs_read && !avs_waitrequest && quiet_bus);
endmodule

// *** dv/tb_sfda_core.sv ***
// self-checking bench for the flag and data address slice of the 8-bit core
// assumes sfda_core alone on a 100 MHz sys_clk, registers reached over avalon-mm
`timescale 1ns/1ps
module tb_sfda_core;
  import sfda_pkg::*;
  typedef struct packed {
    logic [4:0] fl;
    logic [4:0] mask;
    logic [7:0] w;
    logic [11:0] addr;
    logic we;
    logic [7:0] wd;
    logic jv;
    logic [19:0] jt;
  } sfda_exp_s;
  logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, instr_valid, instr_a, instr_d;
  logic mem_we, jump_valid;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] instr_op;
  logic [2:0] instr_bit;
  logic [7:0] instr_file_addr, instr_literal, file_rdata, mem_wdata, flags_out, w_out;
  logic [11:0] instr_dst_addr, mem_addr;
  logic [19:0] instr_prog_addr, jump_target;
  // bench copy of the architectural state
  logic [7:0] w_m;
  logic [4:0] fl_m, mk_m;
  logic [3:0] bsr_m;
  logic ext_m;
  logic [11:0] ptr_m [3];
  sfda_exp_s iq[$];
  logic [31:0] rq[$];
  logic [31:0] rng;
  logic v_d = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [3:0] ops [9] = '{OP_ADD_WORKING_FILE_INSTR, OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR, OP_SUBTRACT_WORKING_INSTR, OP_ANDWF, OP_IORWF, OP_XORWF,
                          OP_RRCF, OP_RLCF};

  sfda_core i_sfda_core (
    .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_file_addr(instr_file_addr), .instr_a(instr_a), .instr_d(instr_d),
    .instr_bit(instr_bit), .instr_literal(instr_literal), .instr_dst_addr(instr_dst_addr),
    .instr_prog_addr(instr_prog_addr), .file_rdata(file_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .flags_out(flags_out), .w_out(w_out),
    .jump_target(jump_target), .jump_valid(jump_valid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic bad(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp_ins(input sfda_exp_s e);
    tests_run++;
    if ((flags_out & {3'h7, e.mask}) !== {3'h0, e.fl & e.mask} || w_out !== e.w ||
        mem_we !== e.we || jump_valid !== e.jv || (e.we && mem_wdata !== e.wd) ||
        (e.jv && jump_target !== e.jt) || (!e.jv && mem_addr !== e.addr))
      bad($sformatf("instr result f=%h w=%h a=%h we=%b", flags_out, w_out, mem_addr, mem_we));
  endtask

  task automatic cmp_rd(input logic [31:0] e);
    tests_run++;
    if (avs_readdata !== e) bad($sformatf("read data %h, wanted %h", avs_readdata, e));
  endtask

  // results are taken from the queues by the watcher only, never by the drivers
  always @(posedge sys_clk) v_d <= instr_valid;
  always @(negedge sys_clk) begin
    if (v_d && iq.size() > 0) cmp_ins(iq.pop_front());
    else if (v_d) bad("result without a note");
    if (avs_read && avs_waitrequest === 1'b0 && rq.size() > 0) cmp_rd(rq.pop_front());
  end

  // a run still going at cycle 5000 ends through the same closing report
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad("timeout");
      test_done();
    end
  end

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {avs_address, avs_read, avs_write, avs_writedata} <= {a, ~wr, wr, d};
    // waitrequest is sampled at the rising edge; the request is released on that same edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad("bus handshake stuck");
    {avs_read, avs_write} <= 2'b00;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ins(input logic [3:0] op, input logic [7:0] fa, input logic a, input logic d,
                     input logic [7:0] lit, input logic [7:0] rdv, input logic [19:0] pa);
    sfda_exp_s e;
    logic [11:0] t;
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] x, y, r, sv;
    logic ci;
    logic [1:0] k;
    logic [2:0] vk;
    @(posedge sys_clk);
    {instr_valid, instr_op, instr_file_addr, instr_a, instr_d, instr_literal, file_rdata,
     instr_dst_addr, instr_prog_addr} <= {1'b1, op, fa, a, d, lit, rdv, pa[11:0], pa};
    t = a ? {bsr_m, fa} : (ext_m && fa < ACC_SPLIT) ? ptr_m[2] + 12'(fa) :
        (fa >= ACC_SPLIT) ? {ACC_HI_BANK, fa} : {4'h0, fa};
    if (op == OP_FILE_TO_FILE_MOVE_INSTR) t = pa[11:0];
    if (t >= ADDR_VIRT && t < ADDR_FLAGS && t[2:0] < VK_PREINC) begin
      k = t[4:3];
      vk = t[2:0];
      t = ptr_m[k];
      if (vk == VK_POST_INCREMENT_OPERAND) ptr_m[k] = ptr_m[k] + 12'h1;
      if (vk == VK_POSTDEC) ptr_m[k] = ptr_m[k] - 12'h1;
    end
    // the flag register is itself the source operand when it is addressed
    sv = (t == ADDR_FLAGS) ? {3'h0, fl_m} : rdv;
    x = (op == OP_ADD_LITERAL_INSTR || op == OP_SUBTRACT_FROM_LITERAL_INSTR) ? lit : sv;
    ci = (op == OP_SUBTRACT_FROM_LITERAL_INSTR || op == OP_SUBTRACT_WORKING_INSTR);
    y = ci ? ~w_m : w_m;
    s = {1'b0, x} + {1'b0, y} + 9'(ci);
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci);
    if (op inside {OP_RRCF, OP_RLCF}) mk_m[FL_DC] = 1'b0;
    if (op inside {OP_ADD_WORKING_FILE_INSTR, OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR, OP_SUBTRACT_WORKING_INSTR}) mk_m = 5'h1f;
    e = '{fl: fl_m, mask: mk_m, w: w_m, addr: t, we: 1'b0, wd: 8'h00, jv: 1'b0, jt: 20'h0};
    case (op)
      OP_ADD_WORKING_FILE_INSTR, OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR, OP_SUBTRACT_WORKING_INSTR: begin
        r = s[7:0];
        e.fl = {r[7], x[7] == y[7] && r[7] != x[7], r == 8'h00, lo[4], s[8]};
      end
      OP_ANDWF: r = sv & w_m;
      OP_IORWF: r = sv | w_m;
      OP_XORWF: r = sv ^ w_m;
      OP_RRCF: r = {fl_m[FL_C], sv[7:1]};
      OP_RLCF: r = {sv[6:0], fl_m[FL_C]};
      OP_CLEAR_FILE_INSTR: r = 8'h00;
      OP_WORKING_TO_FILE_MOVE_INSTR: r = w_m;
      default: r = rdv;
    endcase
    if (op inside {OP_RRCF, OP_RLCF}) e.fl[FL_C] = (op == OP_RRCF) ? sv[0] : sv[7];
    if (op inside {OP_ANDWF, OP_IORWF, OP_XORWF, OP_RRCF, OP_RLCF}) begin
      e.fl[FL_N] = r[7];
      e.fl[FL_Z] = r == 8'h00;
    end
    if (op == OP_CLEAR_FILE_INSTR) e.fl[FL_Z] = 1'b1;
    if (op == OP_JUMP) begin
      e.jv = 1'b1;
      e.jt = pa;
    end else if (op inside {OP_ADD_LITERAL_INSTR, OP_SUBTRACT_FROM_LITERAL_INSTR} || (!d && !(op inside {OP_CLEAR_FILE_INSTR, OP_WORKING_TO_FILE_MOVE_INSTR,
             OP_FILE_TO_FILE_MOVE_INSTR}))) begin
      e.w = r;
    end else if (t == ADDR_FLAGS) begin
      if (op inside {OP_WORKING_TO_FILE_MOVE_INSTR, OP_FILE_TO_FILE_MOVE_INSTR}) e.fl = r[4:0];
      if (op inside {OP_WORKING_TO_FILE_MOVE_INSTR, OP_FILE_TO_FILE_MOVE_INSTR}) mk_m = 5'h1f;
      e.mask = mk_m;
    end else begin
      e.we = 1'b1;
      e.wd = r;
    end
    iq.push_back(e);
    fl_m = e.fl;
    w_m = e.w;
  endtask

  task automatic idle(input string name);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    $display("test %s done", name);
  endtask

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, instr_valid, instr_op, instr_file_addr} = '0;
    {instr_a, instr_d, instr_bit, instr_literal, instr_dst_addr, instr_prog_addr, file_rdata} = '0;
    {w_m, fl_m, bsr_m, ext_m, mk_m} = {8'h00, 5'h00, 4'h0, 1'b0, 5'h1f};
    ptr_m = '{12'h0, 12'h0, 12'h0};
    rng = 32'd12384;
    reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rd(REG_FLAGS, 32'h0);
    bus(1'b1, REG_FLAGS, 32'hffffffff);
    rd(REG_FLAGS, 32'h1f);
    rd(6'h3c, 32'h0);
    idle("registers");
    fl_m = 5'h1f;
    ins(OP_ADD_LITERAL_INSTR, 8'h00, 1'b0, 1'b0, 8'h7f, 8'h00, 20'h0);
    ins(OP_ADD_LITERAL_INSTR, 8'h00, 1'b0, 1'b0, 8'h01, 8'h00, 20'h0);
    ins(OP_SUBTRACT_FROM_LITERAL_INSTR, 8'h00, 1'b0, 1'b0, 8'h80, 8'h00, 20'h0);
    for (int i = 0; i < 60; i++) begin
      rng = xs(rng);
      ins(ops[rng[31:16] % 9], 8'h60 + 8'(rng[5:0]), 1'b0, rng[6], rng[15:8], rng[23:16],
          20'h0);
    end
    idle("flag arithmetic");
    bus(1'b1, REG_FLAGS, 32'h1b);
    {fl_m, mk_m} = {5'h1b, 5'h1f};
    ins(OP_CLEAR_FILE_INSTR, 8'hd8, 1'b0, 1'b1, 8'h00, 8'h55, 20'h0);
    ins(OP_ADD_WORKING_FILE_INSTR, 8'hd8, 1'b0, 1'b1, 8'h00, 8'h80, 20'h0);
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'hd8, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    ins(OP_FILE_TO_FILE_MOVE_INSTR, 8'h00, 1'b0, 1'b1, 8'h00, 8'hea, 20'hfd8);
    idle("flags as destination");
    rd(REG_FLAGS, {27'h0, fl_m});
    bus(1'b1, REG_BSR, 32'h5);
    bsr_m = 4'h5;
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'h34, 1'b1, 1'b1, 8'h00, 8'h00, 20'h0);
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'h34, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'h80, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    ins(OP_FILE_TO_FILE_MOVE_INSTR, 8'h00, 1'b1, 1'b1, 8'h00, 8'h3c, 20'h5a7);
    ins(OP_ADD_WORKING_FILE_INSTR, 8'hff, 1'b1, 1'b1, 8'h00, 8'h91, 20'h0);
    ins(OP_JUMP, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 20'habcde);
    idle("direct addressing");
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b1, REG_PTR2, 32'h200);
    {ext_m, ptr_m[2]} = {1'b1, 12'h200};
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'h10, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    idle("indexed offset");
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_PTR0, 32'h0ff);
    bus(1'b1, REG_PTR1, 32'h100);
    {ext_m, ptr_m[0], ptr_m[1]} = {1'b0, 12'h0ff, 12'h100};
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'hc1, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    ins(OP_ADD_WORKING_FILE_INSTR, 8'hca, 1'b0, 1'b0, 8'h00, 8'h00, 20'h0);
    ins(OP_WORKING_TO_FILE_MOVE_INSTR, 8'hd0, 1'b0, 1'b1, 8'h00, 8'h00, 20'h0);
    idle("indirect");
    rd(REG_PTR0, 32'h100);
    rd(REG_PTR1, 32'h0ff);
    rd(REG_PTR2, 32'h200);
    rd(REG_FLAGS, {27'h0, fl_m});
    repeat (3) @(posedge sys_clk);
    if (iq.size() != 0 || rq.size() != 0) bad("results never appeared");
    test_done();
  end
endmodule
